/* File: hw/adcf_regs.sv */
// Digital feature register bank of a dual-channel converter, reached over
// its three-wire serial control port, plus pin-level feature controls.
// Assumes serial pins, sync, encode clock and the output-disable pin are
// asynchronous to ref_clk and are slow against its 50 MHz rate.
// Behaviour
// - Pattern words split into reset-zero byte registers.
// - Sync functions need master sync enable set.
// - Divider sees sync only with both enables.
// - Next-only low realigns divider every pulse.
// - Next-only high aligns to first pulse only.
// - Divider sync enable self-clears after a next-only sync.
// - Control bit decides if output-disable pin counts.
// - Detect bit starts oscillator below 5 MSPS.
// - Run bit forces oscillator on always.
// - Set bit removes serial data pin pull-down.
module adcf_regs
    import adcf_pkg::*;
#(
    parameter int DIV_RATIO = 4
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        csb,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    input  wire logic        sync_in,
    input  wire logic        enc_clk_in,
    input  wire logic        output_disable_pin,
    input  wire logic [1:0]  chan_select,
    input  wire logic        signature_bit,
    output logic [7:0]       user_pattern_one_high,
    output logic [15:0]      user_pattern_two,
    output logic [1:0]       overrange_pin_en,
    output logic [1:0]       output_channel_sel,
    output logic             divider_tick,
    output logic             osc_on,
    output logic             data_outputs_en,
    output logic             sdio_pulldown_en
);
    typedef enum logic [1:0] {ADCF_IDLE, ADCF_INSTR, ADCF_DATA} adcf_state_e;

    adcf_ctl_if ctl ();

    // Synchroniser chains; stage 1 feeds only stage 2.
    logic [2:0] sclk_s;
    logic [1:0] csb_s, sdio_s, sync_s, enc_s, oeb_s;
    logic       sync_d, enc_d;

    adcf_state_e state, next_state;
    logic [4:0]  bit_cnt, next_bit_cnt;
    logic [15:0] shift_in, next_shift_in;
    logic [7:0]  shift_out, next_shift_out;
    logic [12:0] addr, next_addr;
    logic        is_read, next_is_read;
    logic        next_sdio_out, next_sdio_oe;
    logic        wr_strobe;
    logic [7:0]  wr_data;
    logic        sclk_rise, sclk_fall;

    logic [7:0]  pat1_high, pat2_low, pat2_high, sync_ctl, misc_ctl;
    logic [7:0]  next_pat1_high, next_pat2_low, next_pat2_high;
    logic [7:0]  next_sync_ctl, next_misc_ctl;
    logic [1:0]  ovr_en, next_ovr_en, assign_sel, next_assign_sel;
    logic        sig_bit;

    // Readback of one byte; unmapped and open bits read as zero.
    function automatic logic [7:0] read_mux(input logic [12:0] a);
        logic       ch;
        logic [7:0] v;
        ch = !chan_select[0];
        v  = 8'h00;
        unique case (a)
            ADDR_PAT1_HIGH:  v = pat1_high;
            ADDR_PAT2_LOW:   v = pat2_low;
            ADDR_PAT2_HIGH:  v = pat2_high;
            ADDR_SIG_LOW:    v = {7'h00, sig_bit};
            ADDR_OVR_CTL:    v = {7'h00, ovr_en[ch]};
            ADDR_OUT_ASSIGN: v = {7'h00, assign_sel[ch]};
            ADDR_SYNC_CTL:   v = {5'h00, sync_ctl[2:0]};
            ADDR_MISC_CTL:   v = {misc_ctl[7], 3'h0, misc_ctl[3:2],
                                  1'b0, misc_ctl[0]};
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    assign sclk_rise = sclk_s[1] && !sclk_s[2];
    assign sclk_fall = !sclk_s[1] && sclk_s[2];

    // Serial port sequencer: 16-bit instruction, then streamed data bytes.
    always_comb begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_addr      = addr;
        next_is_read   = is_read;
        next_sdio_out  = sdio_out;
        next_sdio_oe   = sdio_oe;
        wr_strobe      = 1'b0;
        wr_data        = shift_in[7:0];
        if (csb_s[1]) begin
            next_state   = ADCF_IDLE;
            next_sdio_oe = 1'b0;
        end else begin
            unique case (state)
                ADCF_IDLE: begin
                    next_state   = ADCF_INSTR;
                    next_bit_cnt = 5'h00;
                end
                ADCF_INSTR: if (sclk_rise) begin
                    next_shift_in = {shift_in[14:0], sdio_s[1]};
                    next_bit_cnt  = bit_cnt + 5'h01;
                    if (bit_cnt == 5'(INSTR_BITS - 1)) begin
                        next_state     = ADCF_DATA;
                        next_bit_cnt   = 5'h00;
                        next_is_read   = shift_in[INSTR_READ_BIT - 1];
                        next_addr      = {shift_in[11:0], sdio_s[1]};
                        next_shift_out = read_mux({shift_in[11:0],
                                                   sdio_s[1]});
                    end
                end
                ADCF_DATA: begin
                    if (sclk_fall && is_read) begin
                        next_sdio_out  = shift_out[7];
                        next_sdio_oe   = 1'b1;
                        next_shift_out = {shift_out[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        next_shift_in = {shift_in[14:0], sdio_s[1]};
                        next_bit_cnt  = bit_cnt + 5'h01;
                        if (bit_cnt == 5'(BYTE_BITS - 1)) begin
                            wr_strobe      = !is_read;
                            wr_data        = {shift_in[6:0], sdio_s[1]};
                            next_bit_cnt   = 5'h00;
                            next_addr      = addr + 13'h0001;
                            next_shift_out = read_mux(addr + 13'h0001);
                        end
                    end
                end
            endcase
        end
    end

    // Register writes; a hardware clear of the divider enable loses to a
    // write of one in the same cycle so software intent is never dropped.
    always_comb begin
        next_pat1_high  = pat1_high;
        next_pat2_low   = pat2_low;
        next_pat2_high  = pat2_high;
        next_ovr_en     = ovr_en;
        next_assign_sel = assign_sel;
        next_misc_ctl   = misc_ctl;
        next_sync_ctl   = sync_ctl;
        if (ctl.sync_clear)
            next_sync_ctl[SYNC_DIV_BIT] = 1'b0;
        if (wr_strobe) begin
            unique case (addr)
                ADDR_PAT1_HIGH: next_pat1_high = wr_data;
                ADDR_PAT2_LOW:  next_pat2_low  = wr_data;
                ADDR_PAT2_HIGH: next_pat2_high = wr_data;
                ADDR_OVR_CTL: begin
                    if (chan_select[0])
                        next_ovr_en[0] = wr_data[0];
                    if (chan_select[1])
                        next_ovr_en[1] = wr_data[0];
                end
                ADDR_OUT_ASSIGN: begin
                    if (chan_select[0])
                        next_assign_sel[0] = wr_data[0];
                    if (chan_select[1])
                        next_assign_sel[1] = wr_data[0];
                end
                ADDR_SYNC_CTL:  next_sync_ctl = {5'h00, wr_data[2:0]};
                ADDR_MISC_CTL:  next_misc_ctl = wr_data;
                // The signature byte has no write path at all.
                default: ;
            endcase
        end
    end

    assign ctl.master_en   = sync_ctl[SYNC_MASTER_BIT];
    assign ctl.div_sync_en = sync_ctl[SYNC_DIV_BIT];
    assign ctl.next_only   = sync_ctl[SYNC_ONCE_BIT];
    assign ctl.detect_en   = misc_ctl[MISC_DETECT_BIT];
    assign ctl.run_osc     = misc_ctl[MISC_RUN_OSC];

    // All state of the bank, including the pin-facing outputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_s     <= 3'h0;
            csb_s      <= 2'h3;
            sdio_s     <= 2'h0;
            sync_s     <= 2'h0;
            enc_s      <= 2'h0;
            oeb_s      <= 2'h0;
            sync_d     <= 1'b0;
            enc_d      <= 1'b0;
            state      <= ADCF_IDLE;
            bit_cnt    <= 5'h00;
            shift_in   <= 16'h0000;
            shift_out  <= 8'h00;
            addr       <= 13'h0000;
            is_read    <= 1'b0;
            sdio_out   <= 1'b0;
            sdio_oe    <= 1'b0;
            pat1_high  <= RST_PATTERN;
            pat2_low   <= RST_PATTERN;
            pat2_high  <= RST_PATTERN;
            ovr_en     <= {RST_OVR_CTL[0], RST_OVR_CTL[0]};
            assign_sel <= {RST_ASSIGN_B[0], RST_ASSIGN_A[0]};
            sync_ctl   <= RST_SYNC_CTL;
            misc_ctl   <= RST_MISC_CTL;
            sig_bit    <= 1'b0;
            data_outputs_en  <= 1'b1;
            sdio_pulldown_en <= 1'b1;
        end else begin
            sclk_s     <= {sclk_s[1:0], sclk};
            csb_s      <= {csb_s[0], csb};
            sdio_s     <= {sdio_s[0], sdio_in};
            sync_s     <= {sync_s[0], sync_in};
            enc_s      <= {enc_s[0], enc_clk_in};
            oeb_s      <= {oeb_s[0], output_disable_pin};
            sync_d     <= sync_s[1];
            enc_d      <= enc_s[1];
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            shift_in   <= next_shift_in;
            shift_out  <= next_shift_out;
            addr       <= next_addr;
            is_read    <= next_is_read;
            sdio_out   <= next_sdio_out;
            sdio_oe    <= next_sdio_oe;
            pat1_high  <= next_pat1_high;
            pat2_low   <= next_pat2_low;
            pat2_high  <= next_pat2_high;
            ovr_en     <= next_ovr_en;
            assign_sel <= next_assign_sel;
            sync_ctl   <= next_sync_ctl;
            misc_ctl   <= next_misc_ctl;
            sig_bit    <= signature_bit;
            // The pin only counts while its control bit is set.
            data_outputs_en  <= !(misc_ctl[MISC_OE_PIN_BIT] && oeb_s[1]);
            sdio_pulldown_en <= !misc_ctl[MISC_PD_OFF_BIT];
        end
    end

    assign user_pattern_one_high = pat1_high;
    assign user_pattern_two      = {pat2_high, pat2_low};
    assign overrange_pin_en      = ovr_en;
    assign output_channel_sel    = assign_sel;
    assign divider_tick          = ctl.div_tick;
    assign osc_on                = ctl.osc_on;

    adcf_sync_core #(
        .DIV_RATIO (DIV_RATIO)
    ) u_core (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .sync_pulse (sync_s[1] && !sync_d),
        .enc_edge   (enc_s[1] && !enc_d),
        .ctl        (ctl.core)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_pattern_reset;
        disable iff (1'b0) rst |=> user_pattern_two == 16'h0000 &&
                                   user_pattern_one_high == 8'h00;
    endproperty
    a_pattern_reset: assert property (p_pattern_reset) else $error("patterns not zero after reset");
    property p_oe_pin;
        (!misc_ctl[MISC_OE_PIN_BIT])[*2] |-> data_outputs_en;
    endproperty
    a_oe_pin: assert property (p_oe_pin) else $error("disable pin honoured while ignored");
    property p_oe_honour;
        (misc_ctl[MISC_OE_PIN_BIT] && oeb_s[1]) |=> !data_outputs_en;
    endproperty
    a_oe_honour: assert property (p_oe_honour) else $error("disable pin not honoured");
    property p_pulldown;
        misc_ctl[MISC_PD_OFF_BIT] |=> !sdio_pulldown_en;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down kept while disabled");
    property p_sig_ro;
        (wr_strobe && addr == ADDR_SIG_LOW) |=>
            $stable(sync_ctl) && $stable(misc_ctl) && $stable(pat2_low);
    endproperty
    a_sig_ro: assert property (p_sig_ro) else $error("signature write changed state");
endmodule

/* File: hw/adcf_pkg.sv */
// Constants shared by the feature register bank and its sync/oscillator
// helper. Assumes one 50 MHz clock and 13-bit serial port addresses.
package adcf_pkg;
    localparam int          ADDR_W          = 13;
    localparam int          INSTR_BITS      = 16;
    localparam int          BYTE_BITS       = 8;
    // Register offsets.
    localparam logic [12:0] ADDR_PAT1_HIGH  = 13'h001A;
    localparam logic [12:0] ADDR_PAT2_LOW   = 13'h001B;
    localparam logic [12:0] ADDR_PAT2_HIGH  = 13'h001C;
    localparam logic [12:0] ADDR_SIG_LOW    = 13'h0024;
    localparam logic [12:0] ADDR_OVR_CTL    = 13'h002A;
    localparam logic [12:0] ADDR_OUT_ASSIGN = 13'h002E;
    localparam logic [12:0] ADDR_SYNC_CTL   = 13'h0100;
    localparam logic [12:0] ADDR_MISC_CTL   = 13'h0101;
    // Reset values.
    localparam logic [7:0]  RST_PATTERN     = 8'h00;
    localparam logic [7:0]  RST_OVR_CTL     = 8'h01;
    localparam logic [7:0]  RST_ASSIGN_A    = 8'h00;
    localparam logic [7:0]  RST_ASSIGN_B    = 8'h01;
    localparam logic [7:0]  RST_SYNC_CTL    = 8'h01;
    localparam logic [7:0]  RST_MISC_CTL    = 8'h88;
    // Field positions.
    localparam int          SYNC_MASTER_BIT = 0;
    localparam int          SYNC_DIV_BIT    = 1;
    localparam int          SYNC_ONCE_BIT   = 2;
    localparam int          MISC_PD_OFF_BIT = 0;
    localparam int          MISC_RUN_OSC    = 2;
    localparam int          MISC_DETECT_BIT = 3;
    localparam int          MISC_OE_PIN_BIT = 7;
    localparam int          INSTR_READ_BIT  = 15;
    // Timing: sample rate below which the slow-rate detector fires.
    localparam int          CLK_MHZ         = 50;
    localparam int          LOW_RATE_MSPS   = 5;
    localparam int          LOW_RATE_CYC    = CLK_MHZ / LOW_RATE_MSPS;
endpackage

/* File: hw/adcf_ctl_if.sv */
// Control and status carried between the register bank and the sync and
// oscillator helper. Both ends sit on the same clock.
interface adcf_ctl_if;
    logic master_en;
    logic div_sync_en;
    logic next_only;
    logic detect_en;
    logic run_osc;
    logic sync_clear;
    logic osc_on;
    logic div_tick;

    modport regs (output master_en, div_sync_en, next_only, detect_en,
                  run_osc, input sync_clear, osc_on, div_tick);
    modport core (input master_en, div_sync_en, next_only, detect_en,
                  run_osc, output sync_clear, osc_on, div_tick);
endinterface

/* File: hw/adcf_sync_core.sv */
// Reference clock divider with sync realignment and the slow-rate oscillator
// control. Assumes sync and encode edges arrive as one-cycle pulses that
// were already synchronised to ref_clk.
module adcf_sync_core
    import adcf_pkg::*;
#(
    parameter int DIV_RATIO = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic sync_pulse,
    input  wire logic enc_edge,
    adcf_ctl_if.core  ctl
);
    logic [7:0] div_cnt, next_div_cnt;
    logic [7:0] per_cnt, next_per_cnt;
    logic       low_rate, next_low_rate;
    logic       next_sync_clear, next_osc_on, next_div_tick;
    logic       sync_gate;

    // Sync pulses reach the divider only with both enables set.
    assign sync_gate = sync_pulse && ctl.master_en && ctl.div_sync_en;

    // Next state of divider, period meter and oscillator request.
    always_comb begin
        next_div_cnt    = div_cnt + 8'h01;
        next_div_tick   = 1'b0;
        next_sync_clear = 1'b0;
        if (div_cnt == 8'(DIV_RATIO - 1)) begin
            next_div_cnt  = 8'h00;
            next_div_tick = 1'b1;
        end
        if (sync_gate) begin
            next_div_cnt    = 8'h00;
            next_div_tick   = 1'b0;
            // Dropping the enable is what makes later pulses ignored.
            next_sync_clear = ctl.next_only;
        end
        next_per_cnt = enc_edge ? 8'h00 : per_cnt;
        if (!enc_edge && per_cnt < 8'(LOW_RATE_CYC))
            next_per_cnt = per_cnt + 8'h01;
        next_low_rate = low_rate;
        if (!ctl.detect_en)
            next_low_rate = 1'b0;
        else if (per_cnt >= 8'(LOW_RATE_CYC))
            next_low_rate = 1'b1;
        else if (enc_edge)
            next_low_rate = 1'b0;
        // The forced run bit overrides whatever the detector says.
        next_osc_on = ctl.run_osc || (ctl.detect_en && low_rate);
    end

    // Registers only.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt        <= 8'h00;
            per_cnt        <= 8'h00;
            low_rate       <= 1'b0;
            ctl.sync_clear <= 1'b0;
            ctl.osc_on     <= 1'b0;
            ctl.div_tick   <= 1'b0;
        end else begin
            div_cnt        <= next_div_cnt;
            per_cnt        <= next_per_cnt;
            low_rate       <= next_low_rate;
            ctl.sync_clear <= next_sync_clear;
            ctl.osc_on     <= next_osc_on;
            ctl.div_tick   <= next_div_tick;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_gated_pulse;
        sync_pulse && ctl.master_en && ctl.div_sync_en;
    endsequence
    sequence s_quiet_detect;
        (ctl.detect_en && !enc_edge)[*8] ##1 (ctl.detect_en && !enc_edge)[*6];
    endsequence

    // A natural wrap of the divider to zero is not a realignment.
    property p_master_gate;
        (sync_pulse && !ctl.master_en) |=> !ctl.sync_clear &&
            (div_cnt != 8'h00 || $past(div_cnt) == 8'(DIV_RATIO - 1));
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("sync passed without master enable");
    property p_div_gate;
        (sync_pulse && !ctl.div_sync_en) |=> !ctl.sync_clear;
    endproperty
    a_div_gate: assert property (p_div_gate) else $error("sync passed without divider enable");
    property p_continuous;
        (s_gated_pulse and !ctl.next_only) |=> div_cnt == 8'h00 && !ctl.sync_clear;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous sync did not realign");
    property p_once;
        (s_gated_pulse and ctl.next_only) |=> div_cnt == 8'h00 && ctl.sync_clear;
    endproperty
    a_once: assert property (p_once) else $error("one-shot sync did not clear enable");
    property p_detect_off;
        (!ctl.detect_en && !ctl.run_osc)[*2] |-> !ctl.osc_on;
    endproperty
    a_detect_off: assert property (p_detect_off) else $error("oscillator on with detector off");
    property p_slow_rate;
        s_quiet_detect |=> ctl.osc_on;
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow rate did not start oscillator");
    property p_run_osc;
        ctl.run_osc |=> ctl.osc_on;
    endproperty
    a_run_osc: assert property (p_run_osc) else $error("run bit did not force oscillator");
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the feature register bank adcf_regs.
// Assumes the bank alone; every input changes at the falling clock edge.
module tb
    import adcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0, rst = 1'b1, sclk = 1'b0, csb = 1'b1;
    logic        sdio_drv = 1'b0, sync_in = 1'b0, enc_run = 1'b0;
    logic        output_disable_pin = 1'b0, signature_bit = 1'b0;
    logic [1:0]  chan_select = 2'b01;
    logic [2:0]  enc_cnt = 3'h0;
    logic [31:0] seed = 32'hEDB3F07E;
    int          n_errors = 0, comparisons = 0;
    wire         sdio_out, sdio_oe, divider_tick, osc_on;
    wire         data_outputs_en, sdio_pulldown_en;
    wire  [7:0]  user_pattern_one_high;
    wire  [15:0] user_pattern_two;
    wire  [1:0]  overrange_pin_en, output_channel_sel;
    // The data pin carries the bank's bit while it drives, else the bench's.
    wire         sdio_in = sdio_oe ? sdio_out : sdio_drv;
    wire         enc_clk_in = enc_cnt[1];

    // Free-running 50 MHz reference clock.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Encode clock at a quarter of the reference rate; it freezes when idle.
    always @(negedge ref_clk) begin
        if (enc_run) begin
            enc_cnt <= enc_cnt + 3'h1;
        end
    end

    adcf_regs i_dut (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csb(csb),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sync_in(sync_in), .enc_clk_in(enc_clk_in),
        .output_disable_pin(output_disable_pin),
        .chan_select(chan_select), .signature_bit(signature_bit),
        .user_pattern_one_high(user_pattern_one_high),
        .user_pattern_two(user_pattern_two),
        .overrange_pin_en(overrange_pin_en),
        .output_channel_sel(output_channel_sel),
        .divider_tick(divider_tick), .osc_on(osc_on),
        .data_outputs_en(data_outputs_en),
        .sdio_pulldown_en(sdio_pulldown_en)
    );

    // Xorshift source; only the low byte is handed out.
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Expected {oscillator, outputs enabled, pull-down} for a misc value.
    function automatic logic [2:0] misc_exp(input logic [7:0] m,
                                            input logic pin, input logic run);
        return {m[2] | (m[3] & ~run), ~(m[7] & pin), ~m[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One serial bit; half periods of six cycles leave the synchroniser room.
    task automatic sbit(input logic b, output logic got);
        sclk = 1'b0;
        sdio_drv = b;
        tick(6);
        // Sample the pin itself, so an undriven pin shows the bench's bit.
        got = sdio_in;
        sclk = 1'b1;
        tick(6);
    endtask

    task automatic spi(input logic rd, input logic [12:0] addr,
                       input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] ins;
        logic        g;
        ins = {rd, 2'b00, addr};
        csb = 1'b0;
        for (int i = 15; i >= 0; i--) sbit(ins[i], g);
        for (int i = 7; i >= 0; i--) begin
            sbit(wdat[i], g);
            rdat[i] = g;
        end
        sclk = 1'b0;
        sdio_drv = 1'b0;
        tick(6);
        csb = 1'b1;
        tick(8);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi(1'b0, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [12:0] a,
                          input logic [7:0] exp);
        logic [7:0] x;
        spi(1'b1, a, 8'hFF, x);
        check(what, {8'h00, x}, {8'h00, exp});
        check("sdio released", {15'h0, sdio_oe}, 16'h0000);
    endtask

    // Raise sync, then count from a fixed point to the next divider tick.
    task automatic sync_gap(output int d);
        sync_in = 1'b1;
        tick(8);
        d = 0;
        while (divider_tick !== 1'b1 && d < 40) begin
            tick(1);
            d++;
        end
        sync_in = 1'b0;
    endtask

    // Hangs are cut short well beyond the expected run length.
    initial begin
        #1200000;
        n_errors++;
        wrap_up();
    end

    // Main sequence: reset values, registers, sync modes, misc controls.
    initial begin
        logic [7:0] a, b, c, m;
        logic [1:0] ovr, asg;
        int         d0, d1, d2;
        static logic [7:0] modes [4] = '{8'h03, 8'h07, 8'h06, 8'h01};
        static logic [7:0] after [4] = '{8'h03, 8'h05, 8'h06, 8'h01};
        static logic [7:0] cm [3] = '{8'h08, 8'h04, 8'h81};
        static logic [7:0] cb [3] = '{8'h00, 8'h02, 8'h01};
        tick(8);
        rst = 1'b0;
        tick(4);
        check("pattern two", user_pattern_two, 16'h0000);
        check("overrange", {14'h0, overrange_pin_en}, 16'h0003);
        check("assign", {14'h0, output_channel_sel}, 16'h0002);
        check("pull-down", {15'h0, sdio_pulldown_en}, 16'h0001);
        check("outputs on", {15'h0, data_outputs_en}, 16'h0001);
        rd_chk("pattern one", ADDR_PAT1_HIGH, 8'h00);
        rd_chk("sync control", ADDR_SYNC_CTL, RST_SYNC_CTL);
        rd_chk("misc control", ADDR_MISC_CTL, RST_MISC_CTL);
        rd_chk("unmapped", 13'h0030, 8'h00);
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            b = rnd();
            c = rnd();
            wr(ADDR_PAT1_HIGH, a);
            wr(ADDR_PAT2_LOW, b);
            wr(ADDR_PAT2_HIGH, c);
            check("pattern one", {8'h00, user_pattern_one_high}, {8'h00, a});
            check("pattern two", user_pattern_two, {c, b});
            rd_chk("pattern two low", ADDR_PAT2_LOW, b);
        end
        signature_bit = 1'b1;
        wr(ADDR_SIG_LOW, 8'hFE);
        rd_chk("signature", ADDR_SIG_LOW, 8'h01);
        ovr = 2'b11;
        asg = 2'b10;
        for (int i = 0; i < 4; i++) begin
            m = rnd();
            chan_select = (m[1:0] == 2'b00) ? 2'b11 : m[1:0];
            wr(ADDR_OVR_CTL, {7'h00, m[2]});
            wr(ADDR_OUT_ASSIGN, {7'h00, m[3]});
            for (int k = 0; k < 2; k++) begin
                if (chan_select[k]) begin
                    ovr[k] = m[2];
                    asg[k] = m[3];
                end
            end
            check("overrange", {14'h0, overrange_pin_en}, {14'h0, ovr});
            check("assign", {14'h0, output_channel_sel}, {14'h0, asg});
            rd_chk("assign read", ADDR_OUT_ASSIGN, {7'h00, asg[~chan_select[0]]});
        end
        // Pulses one cycle apart in phase only match if the divider realigns.
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYNC_CTL, modes[i]);
            sync_gap(d0);
            tick(10);
            sync_gap(d1);
            tick(11);
            sync_gap(d2);
            check("realigned", {15'h0, d1 == d2}, {15'h0, i == 0});
            // A stalled divider would hit the limit twice and look aligned.
            check("tick seen", {15'h0, d2 < 4}, 16'h0001);
            rd_chk("sync control", ADDR_SYNC_CTL, after[i]);
        end
        for (int i = 0; i < 8; i++) begin
            m = (i < 3) ? cm[i] : (rnd() & 8'h8D);
            b = (i < 3) ? cb[i] : rnd();
            output_disable_pin = b[0];
            enc_run = b[1];
            wr(ADDR_MISC_CTL, m);
            tick(40);
            c = {5'h00, misc_exp(m, b[0], b[1])};
            check("osc", {15'h0, osc_on}, {15'h0, c[2]});
            check("outputs on", {15'h0, data_outputs_en}, {15'h0, c[1]});
            check("pull-down", {15'h0, sdio_pulldown_en}, {15'h0, c[0]});
            rd_chk("misc control", ADDR_MISC_CTL, m);
        end
        wrap_up();
    end
endmodule
